// [hdl/tcb_cfg.svh]
// constants for the trace capture buffer
`ifndef TCB_CFG_SVH
`define TCB_CFG_SVH
`define TCB_TRIG_ID 7'h7D
`define TCB_ADDR_W 40
`define TCB_DATA_W 32
`define TCB_FIFO_DEPTH 16
`define TCB_SRC_N 4
`define TCB_ID_W 7
`define TCB_PAGE_SZ_LOG2 12
`define TCB_PAGE_N 8
`define TCB_MEM_DEPTH 64
`define TCB_RESET_BASE 40'h00_0000_0000
`define TCB_RESET_WMARK 16'h0020
`endif

// [hdl/tcb_pkg.sv]
// types for the trace capture buffer
package tcb_pkg;
  typedef enum logic [1:0] {
    TCB_MODE_CIRC,
    TCB_MODE_ONESHOT
  } tcb_mode_t;
  typedef enum logic [1:0] {
    TCB_ST_IDLE,
    TCB_ST_RUN,
    TCB_ST_STOPPED
  } tcb_state_t;
  typedef enum logic {
    TCB_STORE_LOCAL,
    TCB_STORE_SYSMEM
  } tcb_store_t;
endpackage

// [hdl/tcb_fifo.sv]
// parameterised valid/ready fifo for the trace path
`timescale 1ns/10ps
`default_nettype none
module tcb_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rd_r];
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wr_r] <= in_data_in;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tcb_fifo
`default_nettype wire

// [hdl/tcb_top.sv]
// trace capture buffer: arbitration, formatting, storage and address generation
//
// How it works
// - this block is a trace buffer storing processing element trace.
// - every source port reaches this buffer through the arbiter.
// - one source accepted per cycle; round-robin gives each a share.
// - storage is local memory or a system memory write port, strap chosen.
// - circular mode keeps capturing, overwriting oldest data.
// - system memory addresses are 40 bits wide, any placement.
// - page table splits buffer into pages no larger than the granule.
// - addresses go out as intermediate; second stage translator sits outside.
// - a fixed stream id tags every memory write for the outside translator.
// - page scatter bypass writes one contiguous physical region.
// - a non-secure attribute output lets buffer sit in non-secure memory.
// - several sources packed with id change words, keeping each distinguishable.
// - control inputs work straight after power, no setup sequence needed.
// - control pins are mapped by the system into non-secure space.
// - clock gating hint output drops when capture is idle and the fifo is empty.
// - interrupt pulses at buffer top in circular mode and at watermark.
// - trigger id 0x7D or event-0 input stops capture.
// - warm reset of the element does not touch this block.
`timescale 1ns/10ps
`default_nettype none
`include "tcb_cfg.svh"
module tcb_top #(
  parameter int SRC_N = `TCB_SRC_N,
  parameter int DATA_W = `TCB_DATA_W,
  parameter int ID_W = `TCB_ID_W,
  parameter int ADDR_W = `TCB_ADDR_W,
  parameter int FIFO_DEPTH = `TCB_FIFO_DEPTH,
  parameter int MEM_DEPTH = `TCB_MEM_DEPTH,
  parameter int PAGE_N = `TCB_PAGE_N,
  // stream id value is arbitrary
  parameter int STREAM_ID = 8'h01
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic circular_in,
  input wire logic sysmem_in,
  input wire logic scatter_en_in,
  input wire logic [ADDR_W-1:0] base_in,
  input wire logic [15:0] size_words_in,
  input wire logic [15:0] wmark_in,
  input wire logic [ADDR_W-1:0] page_tab_in [PAGE_N],
  input wire logic [SRC_N-1:0] src_valid_in,
  output logic [SRC_N-1:0] src_ready_out,
  input wire logic [DATA_W-1:0] src_data_in [SRC_N],
  input wire logic [ID_W-1:0] src_id_in [SRC_N],
  input wire logic event0_in,
  input wire logic mem_ready_in,
  output logic mem_wr_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [DATA_W-1:0] mem_data_out,
  output logic [7:0] mem_stream_out,
  output logic mem_nonsecure_out,
  input wire logic [$clog2(MEM_DEPTH)-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out,
  output logic irq_top_out,
  output logic irq_wmark_out,
  output logic wrapped_out,
  output logic stopped_out,
  output logic active_out,
  output logic [15:0] fill_out
);
  localparam int FW = DATA_W + 1;
  localparam int SW = $clog2(SRC_N);
  localparam int MW = $clog2(MEM_DEPTH);
  localparam int PW = `TCB_PAGE_SZ_LOG2 - 2;

  tcb_pkg::tcb_state_t st_r;
  tcb_pkg::tcb_state_t st_nxt;
  logic [SW-1:0] rr_r;
  logic [ID_W-1:0] last_id_r;
  logic id_pend_r;
  logic [15:0] wptr_r;
  logic [15:0] fill_r;
  logic [DATA_W-1:0] lmem_r [MEM_DEPTH];
  logic ev0_s1_r;
  logic ev0_s2_r;

  // arbitration among sources
  // concurrent source share
  logic [SRC_N-1:0] grant;
  logic [SW-1:0] gidx;
  logic gvalid;
  always_comb begin
    grant = '0;
    gidx = '0;
    gvalid = 1'b0;
    for (int k = 0; k < SRC_N; k++) begin
      if (!gvalid && src_valid_in[SW'((32'(rr_r) + k) % SRC_N)]) begin
        gidx = SW'((32'(rr_r) + k) % SRC_N);
        gvalid = 1'b1;
      end
    end
    if (gvalid) begin
      grant[gidx] = 1'b1;
    end
  end

  wire running = (st_r == tcb_pkg::TCB_ST_RUN);
  wire fifo_in_ready;
  wire [ID_W-1:0] gid = src_id_in[gidx];
  // trigger id detect
  wire is_trig = running && gvalid && (gid == `TCB_TRIG_ID);
  wire id_change = gvalid && !is_trig && (gid != last_id_r || id_pend_r);
  // id words go in before the data word
  wire push_id = running && id_change;
  wire push_dat = running && gvalid && !is_trig && !id_change;
  wire fifo_push = push_id || push_dat;
  wire [FW-1:0] fifo_din = push_id ? {1'b1, DATA_W'(gid)} : {1'b0, src_data_in[gidx]};
  // gate sources when not capturing
  // per-source ready
  genvar gi;
  generate
    for (gi = 0; gi < SRC_N; gi++) begin : g_rdy
      assign src_ready_out[gi] = grant[gi] && fifo_in_ready && (push_dat || is_trig);
    end
  endgenerate

  wire fifo_ov;
  wire [FW-1:0] fifo_dout;
  wire drain;
  tcb_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_din),
    .out_valid_out(fifo_ov),
    .out_ready_in(drain),
    .out_data_out(fifo_dout)
  );

  // storage side
  wire at_end = (wptr_r == size_words_in - 16'd1);
  wire full_stop = at_end && !circular_in;
  wire store_ok = !sysmem_in || !mem_wr_out || mem_ready_in;
  assign drain = fifo_ov && store_ok && !(stopped_out && !circular_in && fill_r == size_words_in);
  wire [ADDR_W-1:0] lin_addr = base_in + ADDR_W'({wptr_r, 2'b00});
  wire [15:0] page_idx = wptr_r >> PW;
  wire [ADDR_W-1:0] pg_addr = page_tab_in[page_idx[$clog2(PAGE_N)-1:0]]
    + ADDR_W'({wptr_r[PW-1:0], 2'b00});
  wire [ADDR_W-1:0] phys_addr = scatter_en_in ? pg_addr : lin_addr;

  // event-0 synchroniser
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ev0_s1_r <= 1'b0;
      ev0_s2_r <= 1'b0;
    end else begin
      ev0_s1_r <= event0_in;
      ev0_s2_r <= ev0_s1_r;
    end
  end

  // capture state machine
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      tcb_pkg::TCB_ST_IDLE: begin
        if (enable_in) st_nxt = tcb_pkg::TCB_ST_RUN;
      end
      tcb_pkg::TCB_ST_RUN: begin
        if (!enable_in) st_nxt = tcb_pkg::TCB_ST_IDLE;
        else if (is_trig || ev0_s2_r || (full_stop && drain)) st_nxt = tcb_pkg::TCB_ST_STOPPED;
      end
      tcb_pkg::TCB_ST_STOPPED: begin
        if (!enable_in) st_nxt = tcb_pkg::TCB_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (drain && !sysmem_in) begin
      lmem_r[wptr_r[MW-1:0]] <= fifo_dout[DATA_W-1:0];
    end
    rd_data_out <= lmem_r[rd_addr_in];
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      st_r <= tcb_pkg::TCB_ST_IDLE;
      rr_r <= '0;
      last_id_r <= '0;
      id_pend_r <= 1'b1;
      wptr_r <= '0;
      fill_r <= '0;
      mem_wr_out <= 1'b0;
      mem_addr_out <= '0;
      mem_data_out <= '0;
      irq_top_out <= 1'b0;
      irq_wmark_out <= 1'b0;
      wrapped_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
      irq_top_out <= 1'b0;
      irq_wmark_out <= 1'b0;
      if (gvalid && src_ready_out[gidx]) begin
        rr_r <= (gidx == SW'(SRC_N - 1)) ? '0 : gidx + SW'(1);
      end
      if (push_id && fifo_in_ready) begin
        last_id_r <= gid;
        id_pend_r <= 1'b0;
      end
      if (st_r == tcb_pkg::TCB_ST_IDLE && enable_in) begin
        wptr_r <= '0;
        fill_r <= '0;
        wrapped_out <= 1'b0;
        id_pend_r <= 1'b1;
      end
      if (mem_wr_out && mem_ready_in) begin
        mem_wr_out <= 1'b0;
      end
      if (drain) begin
        if (sysmem_in) begin
          mem_wr_out <= 1'b1;
          mem_addr_out <= phys_addr;
          mem_data_out <= fifo_dout[DATA_W-1:0];
        end
        if (fill_r != size_words_in) begin
          fill_r <= fill_r + 16'd1;
        end
        if (fill_r + 16'd1 == wmark_in) begin
          irq_wmark_out <= 1'b1;
        end
        if (at_end) begin
          wptr_r <= '0;
          if (circular_in) begin
            wrapped_out <= 1'b1;
            irq_top_out <= 1'b1;
          end
        end else begin
          wptr_r <= wptr_r + 16'd1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      mem_stream_out <= '0;
      mem_nonsecure_out <= 1'b0;
      stopped_out <= 1'b0;
      active_out <= 1'b0;
      fill_out <= '0;
    end else begin
      mem_stream_out <= 8'(STREAM_ID);
      mem_nonsecure_out <= 1'b1;
      stopped_out <= (st_nxt == tcb_pkg::TCB_ST_STOPPED);
      active_out <= (st_nxt != tcb_pkg::TCB_ST_IDLE) || fifo_ov;
      fill_out <= fill_r;
    end
  end

  AST_WRAP_FLAG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (drain && at_end && circular_in && running) |=> (wrapped_out && wptr_r == 16'd0))
    else $error("wrap did not set flag");
  AST_TRIG_STOP: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (running && enable_in && is_trig) |=> st_r == tcb_pkg::TCB_ST_STOPPED)
    else $error("trigger did not stop capture");
  AST_HOLD_OFF: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !running |-> !fifo_push)
    else $error("capture while not running");
  AST_IRQ_TOP: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    irq_top_out |-> $past(circular_in) && $past(at_end) && $past(drain))
    else $error("top interrupt without wrap");
  AST_ID_FIRST: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    push_dat |-> gid == last_id_r && !id_pend_r)
    else $error("data pushed without id");
  AST_CONTIG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (drain && sysmem_in && !scatter_en_in) |=> mem_addr_out == $past(lin_addr))
    else $error("contiguous address wrong");
  AST_CIRC: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (running && circular_in && enable_in && !is_trig && !ev0_s2_r) |=> running)
    else $error("circular capture stopped");
  AST_GRANT: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $onehot0(src_ready_out) && (gvalid -> grant != '0))
    else $error("grant broken");
endmodule // tcb_top
`default_nettype wire

// [testbench/tcb_mem_model.sv]
// system memory port partner with optional stalling
`timescale 1ns/10ps
`default_nettype none
module tcb_mem_model (
  input wire logic clk_sys_in,
  input wire logic slow_in,
  output logic mem_ready_out
);
  logic tick_r = 1'b0;
  always @(posedge clk_sys_in) begin
    tick_r <= ~tick_r;
  end
  assign mem_ready_out = ~slow_in | tick_r;
endmodule // tcb_mem_model
`default_nettype wire

// [testbench/trace_capture_buffer_test.sv]
// self-checking bench for the trace capture buffer
`timescale 1ns/10ps
`default_nettype none
module trace_capture_buffer_test;
  logic clk_sys_in, reset_n_in, enable_in, circular_in, sysmem_in, scatter_en_in, event0_in;
  logic [39:0] base_in, mem_addr_out;
  logic [15:0] size_words_in, wmark_in, fill_out;
  logic [39:0] page_tab_in [8];
  logic [3:0] src_valid_in, src_ready_out;
  logic [31:0] src_data_in [4];
  logic [6:0] src_id_in [4];
  logic mem_ready_in, mem_wr_out, mem_nonsecure_out, slow;
  logic [31:0] mem_data_out, rd_data_out;
  logic [7:0] mem_stream_out;
  logic [5:0] rd_addr_in;
  logic irq_top_out, irq_wmark_out, wrapped_out, stopped_out, active_out;
  logic [39:0] wa[$];
  logic [31:0] wd[$];
  int miscompares = 0;
  int comparisons = 0;
  int tops = 0;
  int marks = 0;
  tcb_top u_dut (.clk_sys_in, .reset_n_in, .enable_in, .circular_in, .sysmem_in,
    .scatter_en_in, .base_in, .size_words_in, .wmark_in, .page_tab_in, .src_valid_in,
    .src_ready_out, .src_data_in, .src_id_in, .event0_in, .mem_ready_in, .mem_wr_out,
    .mem_addr_out, .mem_data_out, .mem_stream_out, .mem_nonsecure_out, .rd_addr_in,
    .rd_data_out, .irq_top_out, .irq_wmark_out, .wrapped_out, .stopped_out,
    .active_out, .fill_out);
  tcb_mem_model u_mem (.clk_sys_in(clk_sys_in), .slow_in(slow), .mem_ready_out(mem_ready_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    if (mem_wr_out === 1'b1 && mem_ready_in === 1'b1) begin
      wa.push_back(mem_addr_out);
      wd.push_back(mem_data_out);
    end
    tops += (irq_top_out === 1'b1);
    marks += (irq_wmark_out === 1'b1);
  end
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic cfg(input logic c, s, p, input logic [39:0] b, input logic [15:0] z);
    reset_n_in = 1'b0;
    enable_in = 1'b0;
    event0_in = 1'b0;
    circular_in = c;
    sysmem_in = s;
    scatter_en_in = p;
    base_in = b;
    size_words_in = z;
    cyc(16);
    reset_n_in = 1'b1;
    enable_in = 1'b1;
    cyc(2);
    wa.delete();
    wd.delete();
    tops = 0;
    marks = 0;
  endtask
  // valid stays up unless this is the last word
  task automatic send(input int s, input logic [6:0] id, input logic [31:0] d, input bit last);
    int i;
    src_id_in[s] = id;
    src_data_in[s] = d;
    src_valid_in[s] = 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys_in);
      if (src_ready_out[s] === 1'b1) break;
    end
    #1;
    if (last) src_valid_in[s] = 1'b0;
    if (i == 200) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic wt(input int n);
    int i;
    for (i = 0; i < 300 && wa.size() < n; i++) cyc(1);
    if (i == 300) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic t_contig();
    logic [39:0] b;
    b = 40'hFF_FFFF_FF00;
    slow = 1'b1;
    cfg(1'b0, 1'b1, 1'b0, b, 16'h0010);
    send(0, 7'h11, 32'hA5A5_0001, 0);
    send(0, 7'h11, 32'hA5A5_0002, 1);
    wt(3);
    chk("active", 1, active_out);
    chk("id word", 7'h11, wd[0][6:0]);
    chk("data 1", 32'hA5A5_0001, wd[1]);
    chk("data 2", 32'hA5A5_0002, wd[2]);
    chk("fill", 16'h0003, fill_out);
    for (int k = 0; k < 3; k++) chk("addr", b + 4 * k, wa[k]);
    slow = 1'b0;
  endtask
  task automatic t_two();
    logic [31:0] e;
    logic [3:0] r;
    cfg(1'b0, 1'b1, 1'b0, 40'h00_0000_2000, 16'h0010);
    src_id_in[0] = 7'h21;
    src_id_in[1] = 7'h22;
    src_data_in[0] = 32'h0000_1111;
    src_data_in[1] = 32'h0000_2222;
    src_valid_in = 4'b0011;
    for (int i = 0; i < 100 && src_valid_in != 4'b0000; i++) begin
      @(posedge clk_sys_in);
      r = src_ready_out;
      #1;
      src_valid_in = src_valid_in & ~r;
    end
    wt(4);
    for (int k = 0; k < 4; k += 2) begin
      e = (wd[k][6:0] == 7'h21) ? 32'h0000_1111 : 32'h0000_2222;
      chk("source data", e, wd[k + 1]);
    end
    chk("ids distinct", 1, wd[0][6:0] != wd[2][6:0]);
  endtask
  task automatic t_scatter();
    page_tab_in[0] = 40'h12_3456_7000;
    cfg(1'b0, 1'b1, 1'b1, 40'h00_0000_0000, 16'h0010);
    send(0, 7'h05, 32'hBEEF_0001, 1);
    wt(2);
    chk("page addr", 40'h12_3456_7000, wa[0]);
    chk("page addr", 40'h12_3456_7004, wa[1]);
    chk("stream", 8'h01, mem_stream_out);
    chk("nonsecure", 1, mem_nonsecure_out);
  endtask
  task automatic t_wrap();
    logic [39:0] b;
    b = 40'h00_0000_1000;
    cfg(1'b1, 1'b1, 1'b0, b, 16'h0004);
    for (int k = 0; k < 6; k++) send(0, 7'h07, 32'hC000_0000 + k, k == 5);
    wt(7);
    for (int k = 0; k < 7; k++) chk("wrap addr", b + 4 * (k % 4), wa[k]);
    chk("wrapped", 1, wrapped_out);
    chk("fill", 16'h0004, fill_out);
    chk("top irq", 1, tops > 0);
    chk("mark irq", 1, marks > 0);
  endtask
  task automatic t_stop();
    cfg(1'b1, 1'b1, 1'b0, 40'h00_0000_3000, 16'h0010);
    send(0, 7'h05, 32'h0000_0055, 0);
    send(0, 7'h7D, 32'h0000_0000, 1);
    cyc(4);
    chk("trigger stop", 1, stopped_out);
    src_valid_in[0] = 1'b1;
    cyc(1);
    chk("held off", 0, src_ready_out[0]);
    src_valid_in[0] = 1'b0;
    cfg(1'b1, 1'b1, 1'b0, 40'h00_0000_3000, 16'h0010);
    event0_in = 1'b1;
    cyc(5);
    chk("event stop", 1, stopped_out);
  endtask
  task automatic t_local();
    cfg(1'b0, 1'b0, 1'b0, 40'h00_0000_0000, 16'h0010);
    send(0, 7'h09, 32'h1234_5678, 1);
    cyc(20);
    chk("no sysmem", 0, wa.size());
    rd_addr_in = 6'h01;
    cyc(2);
    chk("local data", 32'h1234_5678, rd_data_out);
  endtask
  initial begin
    {enable_in, circular_in, sysmem_in, scatter_en_in, event0_in, slow} = '0;
    reset_n_in = 1'b0;
    base_in = '0;
    size_words_in = 16'h0010;
    wmark_in = 16'h0002;
    page_tab_in = '{default: '0};
    src_valid_in = 4'h0;
    src_data_in = '{default: '0};
    src_id_in = '{default: '0};
    rd_addr_in = '0;
    cyc(16);
    chk("wr idle", 0, mem_wr_out);
    chk("wrapped idle", 0, wrapped_out);
    chk("stopped idle", 0, stopped_out);
    t_contig();
    t_two();
    t_scatter();
    t_wrap();
    t_stop();
    t_local();
    stop_test();
  end
endmodule // trace_capture_buffer_test
`default_nettype wire
